// file: core/nsk_pkg.sv
// Purpose: Shared constants for the set and skip instruction slice.
// Assumes: 10-bit instruction words from program ROM, one word per cycle.
// Notes:   Opcode values are the instruction encodings of the core.
package nsk_pkg;
   localparam int          INSN_W             = 10;
   localparam int          ACC_W              = 4;
   localparam int          PORT_D_W           = 8;
   localparam int          PAGE_W             = 7;
   localparam logic [9:0]  OP_SELECT_BANK     = 10'h041;
   localparam logic [9:0]  OP_SET_CARRY       = 10'h007;
   localparam logic [9:0]  OP_SET_SINGLE_PORT = 10'h28d;
   localparam logic [9:0]  OP_SET_INDEXED     = 10'h015;
   localparam logic [9:0]  OP_SKIP_EQ_IMM     = 10'h025;
   localparam logic [9:0]  OP_TABLE_LOOKUP    = 10'h080;
   localparam logic [9:0]  TABLE_LOOKUP_MASK  = 10'h3c0;
   localparam logic [9:0]  IMM_PREFIX         = 10'h070;
   localparam logic [9:0]  IMM_PREFIX_MASK    = 10'h3f0;
   localparam int          PAGE_BIT6_POS      = 6;
   localparam logic        BANK_RST           = 1'b0;
   localparam logic        CARRY_RST          = 1'b0;
   localparam logic        PORT_C_RST         = 1'b0;
   localparam logic [7:0]  PORT_D_RST         = 8'h00;
   localparam logic [6:0]  PAGE_RST           = 7'h00;
   localparam int          INDEX_W            = 4;
   typedef enum logic [0:0] {
      NSK_FETCH = 1'b0,
      NSK_IMM   = 1'b1
   } nsk_state_t;
endpackage

// file: core/nsk_decode.sv
// Purpose: Classifies one instruction word for the set and skip slice.
// Assumes: Word is stable for the cycle it is presented.
// Notes:   Pure combinational decode, kept apart so the main file stays sequential.
`timescale 1ns/100ps
module nsk_decode
   import nsk_pkg::*;
(
   input  wire logic [nsk_pkg::INSN_W-1:0] insn_i,
   output logic                            is_bank_o,
   output logic                            is_carry_o,
   output logic                            is_port_c_o,
   output logic                            is_port_d_o,
   output logic                            is_seq_o,
   output logic                            is_table_o
);
   always_comb begin
      is_bank_o   = (insn_i == OP_SELECT_BANK);
      is_carry_o  = (insn_i == OP_SET_CARRY);
      is_port_c_o = (insn_i == OP_SET_SINGLE_PORT);
      is_port_d_o = (insn_i == OP_SET_INDEXED);
      is_seq_o    = (insn_i == OP_SKIP_EQ_IMM);
      is_table_o  = ((insn_i & TABLE_LOOKUP_MASK) == OP_TABLE_LOOKUP);
   end
endmodule

// file: core/nsk_core.sv
// Purpose: Execute slice for bank, carry, port set and compare-skip instructions.
// Assumes: One instruction word per clock; words arriving while a skip is
//          pending are the skipped word and are not executed here.
// Notes:   Other instructions pass without effect on this slice's state.
//          The bank flag is sticky: no op of this slice clears it, only reset.
//          Skip state is kept inside and clears on the next valid word, so idle
//          cycles between a compare and the skipped word are harmless.
//
// Summary of operation
// RL1 - After bank select, a table lookup forces page bit 6 high.
// RL2 - Set carry writes one to carry; one word, one cycle, no skip.
// RL3 - Indexed port set drives the port D bit chosen by index 0 to 7.
// RL4 - Compare with immediate is two words, two cycles, 4-bit immediate.
// RL5 - Equal compare skips next instruction; carry is never changed.
// RL6 - Single port set drives port C high; carry and skip untouched.
`timescale 1ns/100ps
module nsk_core
   import nsk_pkg::*;
(
   input  wire logic                              SYS_CLK_I,
   input  wire logic                              RST_N_I,
   input  wire logic                              INSN_VALID_I,
   input  wire logic [nsk_pkg::INSN_W-1:0]        INSN_I,
   input  wire logic [nsk_pkg::ACC_W-1:0]         ACC_I,
   input  wire logic [nsk_pkg::INDEX_W-1:0]       INDEX_Y_I,
   input  wire logic [nsk_pkg::PAGE_W-1:0]        TABLE_PAGE_I,
   output logic                                   CARRY_FLAG_O,
   output logic                                   PORT_C_O,
   output logic [nsk_pkg::PORT_D_W-1:0]           PORT_D_O,
   output logic                                   BANK_FLAG_O,
   output logic [nsk_pkg::PAGE_W-1:0]             TABLE_PAGE_O,
   output logic                                   TABLE_PAGE_VALID_O,
   output logic                                   SKIP_NEXT_O,
   output logic                                   BUSY_O
);
   import nsk_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic       is_bank;
   logic       is_carry;
   logic       is_port_c;
   logic       is_port_d;
   logic       is_seq;
   logic       is_table;
   logic       exec;
   nsk_state_t state_reg;
   nsk_state_t state_next;
   logic       skip_reg;
   logic       do_carry;
   logic       do_port_c;
   logic       do_port_d;
   logic       do_bank;
   logic       do_table;
   logic       imm_take;
   logic       imm_match;
   logic       index_ok;
   logic       skip_set;
   logic       skip_clear;

   ////////////////////////////////////////////////////////////////////////////
   // A second word without the immediate prefix never matches, so a compare whose
   // pair was broken by a stray word falls through instead of skipping.
   function automatic logic has_imm_prefix(input logic [nsk_pkg::INSN_W-1:0] word);
      has_imm_prefix = ((word & IMM_PREFIX_MASK) == IMM_PREFIX);
   endfunction

   function automatic logic imm_hit(input logic [nsk_pkg::INSN_W-1:0] word,
                                    input logic [nsk_pkg::ACC_W-1:0]  acc);
      imm_hit = has_imm_prefix(word) && (word[ACC_W-1:0] == acc);
   endfunction

   function automatic logic [nsk_pkg::PAGE_W-1:0] page_with_bank(
      input logic [nsk_pkg::PAGE_W-1:0] page,
      input logic                       bank
   );
      logic [nsk_pkg::PAGE_W-1:0] forced;
      forced                = page;
      forced[PAGE_BIT6_POS] = page[PAGE_BIT6_POS] | bank;
      page_with_bank        = forced;
   endfunction

   function automatic logic [nsk_pkg::PORT_D_W-1:0] port_d_with_bit(
      input logic [nsk_pkg::PORT_D_W-1:0] port,
      input logic [nsk_pkg::INDEX_W-2:0]  idx
   );
      logic [nsk_pkg::PORT_D_W-1:0] value;
      value           = port;
      value[idx]      = 1'b1;
      port_d_with_bit = value;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   nsk_decode u_decode (
      .insn_i      (INSN_I),
      .is_bank_o   (is_bank),
      .is_carry_o  (is_carry),
      .is_port_c_o (is_port_c),
      .is_port_d_o (is_port_d),
      .is_seq_o    (is_seq),
      .is_table_o  (is_table)
   );

   // A skipped word still occupies its cycle, so it is consumed but not executed.
   assign exec       = INSN_VALID_I && (state_reg == NSK_FETCH) && !skip_reg;
   assign do_carry   = exec && is_carry;
   assign do_port_c  = exec && is_port_c;
   // Index values 8 and above are undefined for this op, so they leave the port alone.
   assign index_ok   = !INDEX_Y_I[INDEX_W-1];
   assign do_port_d  = exec && is_port_d && index_ok;
   assign do_bank    = exec && is_bank;
   assign do_table   = exec && is_table;
   assign imm_take   = (state_reg == NSK_IMM) && INSN_VALID_I;
   assign imm_match  = imm_hit(INSN_I, ACC_I);
   assign skip_set   = imm_take && imm_match;
   assign skip_clear = INSN_VALID_I && skip_reg;

   ////////////////////////////////////////////////////////////////////////////
   // The compare holds fetch away for exactly one valid word, however late it comes.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         NSK_FETCH: begin
            if (exec && is_seq) begin
               state_next = NSK_IMM; // [RL4]
            end
         end
         NSK_IMM: begin
            if (INSN_VALID_I) begin
               state_next = NSK_FETCH; // [RL4]
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         state_reg <= NSK_FETCH;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The equality is taken on the second word; its upper bits are the operand prefix.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         skip_reg <= 1'b0;
      end else if (imm_take) begin
         skip_reg <= skip_set; // [RL5]
      end else if (skip_clear) begin
         skip_reg <= 1'b0; // [RL5]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Carry is only ever set here; the compare leaves it alone.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         CARRY_FLAG_O <= CARRY_RST;
      end else if (do_carry) begin
         CARRY_FLAG_O <= 1'b1; // [RL2]
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         PORT_C_O <= PORT_C_RST;
      end else if (do_port_c) begin
         PORT_C_O <= 1'b1; // [RL6]
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         PORT_D_O <= PORT_D_RST;
      end else if (do_port_d) begin
         PORT_D_O <= port_d_with_bit(PORT_D_O, INDEX_Y_I[INDEX_W-2:0]); // [RL3]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         BANK_FLAG_O <= BANK_RST;
      end else if (do_bank) begin
         BANK_FLAG_O <= 1'b1; // [RL1]
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         TABLE_PAGE_O <= PAGE_RST;
      end else if (do_table) begin
         TABLE_PAGE_O <= page_with_bank(TABLE_PAGE_I, BANK_FLAG_O); // [RL1]
      end
   end

   // The pulse marks the one cycle in which the page is fresh.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         TABLE_PAGE_VALID_O <= 1'b0;
      end else begin
         TABLE_PAGE_VALID_O <= do_table; // [RL1]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         SKIP_NEXT_O <= 1'b0;
      end else begin
         SKIP_NEXT_O <= skip_set; // [RL5]
      end
   end

   // Busy follows the next state so it rises together with the wait for word two.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         BUSY_O <= 1'b0;
      end else begin
         BUSY_O <= (state_next == NSK_IMM); // [RL4]
      end
   end
endmodule

// file: sim/nsk_rom_model.sv
// Purpose: Program memory stand-in that hands one word per cycle to the slice.
// Assumes: The bench asks for a word one cycle before the slice should take it.
// Notes:   Idle cycles invert the output word every cycle, so stale data never looks valid.
`timescale 1ns/100ps
module nsk_rom_model (
   input  wire logic       clk_i,
   input  wire logic       req_i,
   input  wire logic [9:0] word_i,
   output logic            valid_o,
   output logic [9:0]      insn_o
);
   initial begin
      valid_o = 1'b0;
      insn_o  = 10'h000;
   end
   always @(posedge clk_i) begin
      valid_o <= req_i;
      insn_o  <= req_i ? word_i : ~insn_o;
   end
endmodule

// file: sim/nsk_core_properties.sv
// Purpose: Port checker for the set and skip slice.
// Assumes: Only the ports of nsk_core are visible.
// Notes:   Words hidden by a pending skip are left out of the per-op checks.
`timescale 1ns/100ps
module nsk_core_chk
   import nsk_pkg::*;
(
   input wire logic                  SYS_CLK_I,
   input wire logic                  RST_N_I,
   input wire logic                  INSN_VALID_I,
   input wire logic [INSN_W-1:0]     INSN_I,
   input wire logic [ACC_W-1:0]      ACC_I,
   input wire logic [INDEX_W-1:0]    INDEX_Y_I,
   input wire logic                  CARRY_FLAG_O,
   input wire logic                  PORT_C_O,
   input wire logic [PORT_D_W-1:0]   PORT_D_O,
   input wire logic                  BANK_FLAG_O,
   input wire logic [PAGE_W-1:0]     TABLE_PAGE_O,
   input wire logic                  TABLE_PAGE_VALID_O,
   input wire logic                  SKIP_NEXT_O,
   input wire logic                  BUSY_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   logic skip_pend;
   logic take;
   // A skip can wait across idle cycles, so the next valid word stays hidden until then.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I || INSN_VALID_I) begin
         skip_pend <= 1'b0;
      end else if (SKIP_NEXT_O) begin
         skip_pend <= 1'b1;
      end
   end
   assign take = INSN_VALID_I && !BUSY_O && !SKIP_NEXT_O && !skip_pend;
   sequence op_s(logic [9:0] op);
      take && INSN_I == op;
   endsequence
   sequence imm_s;
      BUSY_O && INSN_VALID_I && (INSN_I & IMM_PREFIX_MASK) == IMM_PREFIX;
   endsequence
   a_bank_page_high: assert property (
      BANK_FLAG_O && take && (INSN_I & TABLE_LOOKUP_MASK) == OP_TABLE_LOOKUP
      |=> TABLE_PAGE_VALID_O && TABLE_PAGE_O[PAGE_BIT6_POS])
      else $error("page bit 6 not forced");
   a_carry_set: assert property (
      op_s(OP_SET_CARRY) |=> CARRY_FLAG_O && !SKIP_NEXT_O)
      else $error("carry not set");
   a_port_d_bit: assert property (
      op_s(OP_SET_INDEXED) ##0 (INDEX_Y_I < 4'h8) |=> PORT_D_O[$past(INDEX_Y_I[2:0])])
      else $error("port bit not set");
   a_port_d_refused: assert property (
      op_s(OP_SET_INDEXED) ##0 INDEX_Y_I[3] |=> $stable(PORT_D_O))
      else $error("port changed on bad index");
   a_compare_busy: assert property (
      op_s(OP_SKIP_EQ_IMM) |=> BUSY_O && !SKIP_NEXT_O)
      else $error("compare not two words");
   a_skip_equal: assert property (
      imm_s ##0 (INSN_I[3:0] == ACC_I) |=> SKIP_NEXT_O && !BUSY_O ##1 !SKIP_NEXT_O)
      else $error("no skip on equal");
   a_no_skip_ne: assert property (
      imm_s ##0 (INSN_I[3:0] != ACC_I) |=> !SKIP_NEXT_O)
      else $error("skip on unequal");
   a_carry_kept: assert property (
      BUSY_O |=> $stable(CARRY_FLAG_O))
      else $error("carry changed by compare");
   a_port_c_set: assert property (
      op_s(OP_SET_SINGLE_PORT) |=> PORT_C_O && !SKIP_NEXT_O && $stable(CARRY_FLAG_O))
      else $error("port c not set");
endmodule
bind nsk_core nsk_core_chk u_nsk_core_chk (.SYS_CLK_I, .RST_N_I, .INSN_VALID_I, .INSN_I,
   .ACC_I, .INDEX_Y_I, .CARRY_FLAG_O, .PORT_C_O, .PORT_D_O, .BANK_FLAG_O, .TABLE_PAGE_O,
   .TABLE_PAGE_VALID_O, .SKIP_NEXT_O, .BUSY_O);

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the set and skip slice.
// Assumes: Side inputs change only while no word is in flight.
// Notes:   Words reach the slice one cycle after the bench asks the memory model.
`timescale 1ns/100ps
module tb_top;
   import nsk_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, vld, carry, pc, bank, pgv, skip, busy;
   logic [9:0] word = 10'h000, insn;
   logic [3:0] acc = 4'h0, y = 4'h0;
   logic [6:0] pg_i = 7'h05, pg;
   logic [7:0] pd;
   int num_errors = 0, checks_done = 0, cyc = 0;
   int skip_seen = 0, busy_seen = 0, page_seen = 0;
   initial forever #2.5 clk = ~clk;
   nsk_rom_model u_nsk_rom_model (.clk_i(clk), .req_i(req), .word_i(word), .valid_o(vld), .insn_o(insn));
   nsk_core u_nsk_core (.SYS_CLK_I(clk), .RST_N_I(rst_n), .INSN_VALID_I(vld), .INSN_I(insn),
      .ACC_I(acc), .INDEX_Y_I(y), .TABLE_PAGE_I(pg_i), .CARRY_FLAG_O(carry), .PORT_C_O(pc),
      .PORT_D_O(pd), .BANK_FLAG_O(bank), .TABLE_PAGE_O(pg), .TABLE_PAGE_VALID_O(pgv),
      .SKIP_NEXT_O(skip), .BUSY_O(busy));
   task chk(string n, logic [7:0] s, logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task send(logic [9:0] w);
      @(posedge clk);
      req  <= 1'b1;
      word <= w;
   endtask
   task idle(int n);
      @(posedge clk);
      req <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task finish_test();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // The ceiling leaves ample room over the roughly 95 cycles the tests need.
   always @(posedge clk) begin
      cyc++;
      // Pulses stand one cycle, so they are counted as they pass and compared at the end.
      if (skip === 1'b1) skip_seen++;
      if (busy === 1'b1) busy_seen++;
      if (pgv === 1'b1) page_seen++;
      if (cyc == 2000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      idle(1);
      chk("port_d", pd, 8'h00);
      y <= 4'h8;
      send(OP_SET_INDEXED); idle(3); chk("port_d", pd, 8'h00);
      for (int i = 0; i < 8; i++) begin
         y <= i[3:0];
         send(OP_SET_INDEXED); idle(3); chk("port_d", pd, 8'hff >> (7 - i));
      end
      acc <= 4'h9;
      send(OP_SKIP_EQ_IMM); send(IMM_PREFIX | 10'h009); send(OP_SET_CARRY);
      idle(3); chk("carry", {7'h00, carry}, 8'h00);
      send(OP_SKIP_EQ_IMM); send(IMM_PREFIX | 10'h00f); send(OP_SET_CARRY);
      idle(3); chk("carry", {7'h00, carry}, 8'h01);
      acc <= 4'h0;
      send(OP_SKIP_EQ_IMM); send(IMM_PREFIX); send(OP_SET_SINGLE_PORT);
      idle(3); chk("port_c", {7'h00, pc}, 8'h00);
      send(OP_SET_SINGLE_PORT); idle(3); chk("port_c", {7'h00, pc}, 8'h01);
      send(OP_TABLE_LOOKUP); idle(3); chk("page", {1'b0, pg}, 8'h05);
      send(OP_SELECT_BANK); send(OP_TABLE_LOOKUP);
      idle(3); chk("page", {1'b0, pg}, 8'h45);
      send(OP_SKIP_EQ_IMM); send(10'h000); idle(3);
      chk("bank", {7'h00, bank}, 8'h01);
      chk("page_valid", page_seen[7:0], 8'h02);
      chk("busy", busy_seen[7:0], 8'h04);
      chk("skips", skip_seen[7:0], 8'h02);
      finish_test();
   end
endmodule
